// ### rtl/asa_pkg.sv
package asa_pkg;
	// clock and memory timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int ACC_FAST_NS = 25;
	localparam int ACC_SLOW_NS = 45;
	// least time, so round up, and never below one cycle
	localparam int ACC_FAST_CYC_I = (ACC_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_SLOW_CYC_I = (ACC_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] ACC_FAST_CYC = 3'(ACC_FAST_CYC_I < 1 ? 1 : ACC_FAST_CYC_I);
	localparam logic [2:0] ACC_SLOW_CYC = 3'(ACC_SLOW_CYC_I < 1 ? 1 : ACC_SLOW_CYC_I);

	// memory geometry
	localparam int ADDR_PINS = 14;
	localparam int ADDR_BITS = 11;
	localparam int DATA_BITS = 8;
	localparam int RD_BYTES = 6;
	localparam logic [2:0] RD_MAX_LEN = 3'h6;
	localparam logic [10:0] LAST_ADDR_1K = 11'h3ff;
	localparam logic [10:0] LAST_ADDR_2K = 11'h7ff;
	localparam logic [10:0] PAGE_STRIDE = 11'h040;
	localparam logic [10:0] HUB1_BASE = 11'h400;
	localparam logic [3:0] LAST_PORT = 4'hc;
	localparam logic [10:0] HUB0_RESERVED_LO = 11'h340;
	// attribute offsets inside a port page
	localparam logic [5:0] OFS_COUNTER_STEP = 6'h04;
	localparam logic [5:0] OFS_LAST_COUNTER = 6'h28;
	localparam logic [5:0] OFS_SRC_ADDR = 6'h2c;
	localparam logic [5:0] OFS_SRC_CHANGE = 6'h32;
	localparam logic [5:0] OFS_STATUS1 = 6'h36;
	localparam logic [5:0] OFS_STATUS2 = 6'h37;
	localparam int MGMT_TAIL_BYTES = 7;

	// reset values
	localparam logic [13:0] RST_MEM_ADDR = 14'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_STROBE = 4'h4,
		ST_FINISH = 4'h8
	} asa_state_e;

	// software control bits
	typedef struct packed {
		logic size_2k;
		logic speed_slow;
		logic begin_read;
		logic begin_write;
		logic fill;
		logic hub_sel;
		logic [3:0] port;
		logic [5:0] offset;
		logic [2:0] rd_len;
		logic [7:0] wdata;
	} asa_cfg_s;

	// automatic attribute update request
	typedef struct packed {
		logic valid;
		logic write;
		logic [10:0] addr;
		logic [7:0] wdata;
	} asa_upd_s;

	// memory pin group, strobes active low
	typedef struct packed {
		logic [13:0] addr;
		logic [7:0] dout;
		logic dout_oe;
		logic write_strobe_n;
		logic output_enable_n;
		logic read_write_level;
	} asa_mem_s;
endpackage : asa_pkg

// ### rtl/asa_sram_engine.sv
`timescale 1ns/1ps
module asa_sram_engine
	import asa_pkg::*;
(
	input wire logic i_clock, // system clock
	input wire logic i_resetn, // synchronous reset, active low
	input wire asa_cfg_s i_cfg, // software control bits
	input wire asa_upd_s i_upd, // automatic update request
	output logic o_upd_ready, // update request taken
	output logic [7:0] o_upd_rdata, // update read byte
	output logic o_upd_rvalid, // update access finished
	input wire logic [7:0] i_memory_data_in, // data lines as seen
	output asa_mem_s o_mem, // memory pin group
	output logic [47:0] o_read_data, // six read holding bytes
	output logic o_clear_begin_read, // pulse: drop begin-read
	output logic o_clear_begin_write, // pulse: drop begin-write
	output logic o_read_done_flag, // pulse: cpu read done
	output logic o_write_done_flag, // pulse: cpu write or fill done
	output logic o_busy // memory cycle in progress
);

	// whole module state
	typedef struct packed {
		asa_state_e st;
		logic [10:0] addr; // current byte address
		logic [10:0] last; // last address of a fill
		logic [2:0] tmr; // strobe cycles left
		logic [2:0] left; // read bytes left
		logic [2:0] idx; // holding byte index
		logic own_upd; // cycle belongs to updater
		logic is_write; // cycle is a write
		logic is_fill; // fill in progress
		logic [7:0] wbyte; // byte being written
		logic rd_pend; // cpu read waiting
		logic wr_pend; // cpu write waiting
		logic rd_prev; // begin-read last cycle
		logic wr_prev; // begin-write last cycle
		logic cpu_turn; // cpu has priority next
		logic [47:0] rdata;
		asa_mem_s mem;
		logic upd_ready;
		logic [7:0] upd_rdata;
		logic upd_rvalid;
		logic clr_rd;
		logic clr_wr;
		logic rd_done;
		logic wr_done;
		logic busy;
	} asa_regs_s;

	asa_regs_s cur_ff;
	asa_regs_s nxt_cur;

	// page address from hub, port and offset
	function automatic logic [10:0] page_addr(input logic hub, input logic [3:0] port, input logic [5:0] ofs,
		input logic big);
		logic [10:0] a;
		// ports past twelve land in reserved space
		a = {hub, port, ofs};
		// 1k part has no bit 10, so the second hub folds away
		if (!big)
			a[10] = 1'b0;
		return a;
	endfunction : page_addr

	// strobe length for the chosen speed
	function automatic logic [2:0] strobe_len(input logic slow);
		return slow ? ACC_SLOW_CYC : ACC_FAST_CYC;
	endfunction : strobe_len

	// next state
	always_comb
	begin
		logic cpu_req;
		logic take_cpu;
		logic rd_rise;
		logic wr_rise;
		cpu_req = 1'b0;
		take_cpu = 1'b0;
		// begin bits seen rising this cycle
		rd_rise = i_cfg.begin_read && !cur_ff.rd_prev;
		wr_rise = i_cfg.begin_write && !cur_ff.wr_prev;
		nxt_cur = cur_ff;
		// single-cycle pulses fall back
		nxt_cur.upd_ready = 1'b0;
		nxt_cur.upd_rvalid = 1'b0;
		nxt_cur.clr_rd = 1'b0;
		nxt_cur.clr_wr = 1'b0;
		nxt_cur.rd_done = 1'b0;
		nxt_cur.wr_done = 1'b0;
		nxt_cur.rd_prev = i_cfg.begin_read;
		nxt_cur.wr_prev = i_cfg.begin_write;
		if (rd_rise)
			nxt_cur.rd_pend = 1'b1;
		if (wr_rise)
			nxt_cur.wr_pend = 1'b1;
		case (cur_ff.st)
			ST_IDLE:
			begin
				nxt_cur.mem.dout_oe = 1'b0;
				nxt_cur.mem.write_strobe_n = 1'b1;
				nxt_cur.mem.output_enable_n = 1'b1;
				nxt_cur.mem.read_write_level = 1'b1;
				cpu_req = cur_ff.rd_pend || cur_ff.wr_pend;
				// alternate priority so the cpu always gets in
				take_cpu = cpu_req && (cur_ff.cpu_turn || !i_upd.valid);
				if (take_cpu)
				begin
					nxt_cur.st = ST_SETUP;
					nxt_cur.own_upd = 1'b0;
					nxt_cur.cpu_turn = 1'b0;
					nxt_cur.busy = 1'b1;
					nxt_cur.idx = 3'h0;
					nxt_cur.wbyte = i_cfg.wdata;
					nxt_cur.addr = page_addr(i_cfg.hub_sel, i_cfg.port, i_cfg.offset, i_cfg.size_2k);
					// fill stops at the configured size
					nxt_cur.last = i_cfg.size_2k ? LAST_ADDR_2K : LAST_ADDR_1K;
					if (cur_ff.wr_pend)
					begin
						nxt_cur.is_write = 1'b1;
						// a fresh rise in the taking cycle stays queued
						nxt_cur.wr_pend = wr_rise;
						nxt_cur.is_fill = i_cfg.fill;
						if (i_cfg.fill)
							nxt_cur.addr = 11'h000;
					end
					else
					begin
						nxt_cur.is_write = 1'b0;
						nxt_cur.is_fill = 1'b0;
						nxt_cur.rd_pend = rd_rise;
						nxt_cur.rdata = '0;
						// zero length reads one, above six reads six
						if (i_cfg.rd_len == 3'h0)
							nxt_cur.left = 3'h1;
						else if (i_cfg.rd_len > RD_MAX_LEN)
							nxt_cur.left = RD_MAX_LEN;
						else
							nxt_cur.left = i_cfg.rd_len;
					end
				end
				else if (i_upd.valid)
				begin
					nxt_cur.st = ST_SETUP;
					nxt_cur.own_upd = 1'b1;
					nxt_cur.cpu_turn = 1'b1;
					nxt_cur.busy = 1'b1;
					nxt_cur.upd_ready = 1'b1;
					nxt_cur.is_write = i_upd.write;
					nxt_cur.is_fill = 1'b0;
					nxt_cur.wbyte = i_upd.wdata;
					nxt_cur.addr = i_upd.addr;
					nxt_cur.left = 3'h1;
				end
				else
					nxt_cur.busy = 1'b0;
			end
			ST_SETUP:
			begin
				// address settles before any strobe
				// level high for read, low for write
				nxt_cur.mem.read_write_level = !cur_ff.is_write;
				nxt_cur.mem.dout_oe = cur_ff.is_write;
				// strobe held for the access time
				nxt_cur.tmr = strobe_len(i_cfg.speed_slow);
				nxt_cur.mem.write_strobe_n = !cur_ff.is_write;
				nxt_cur.mem.output_enable_n = cur_ff.is_write;
				nxt_cur.st = ST_STROBE;
			end
			ST_STROBE:
			begin
				if (cur_ff.tmr > 3'h1)
					nxt_cur.tmr = cur_ff.tmr - 3'h1;
				else
				begin
					// strobe ends; write data stays one more cycle for hold
					nxt_cur.mem.write_strobe_n = 1'b1;
					nxt_cur.mem.output_enable_n = 1'b1;
					nxt_cur.st = ST_FINISH;
					if (!cur_ff.is_write)
					begin
						if (cur_ff.own_upd)
							nxt_cur.upd_rdata = i_memory_data_in;
						else
							nxt_cur.rdata[cur_ff.idx * 8 +: 8] = i_memory_data_in;
					end
				end
			end
			ST_FINISH:
			begin
				nxt_cur.mem.dout_oe = 1'b0;
				nxt_cur.mem.read_write_level = 1'b1;
				nxt_cur.st = ST_IDLE;
				if (cur_ff.own_upd)
				begin
					nxt_cur.upd_rvalid = 1'b1;
					nxt_cur.busy = 1'b0;
				end
				// walk every location of the memory
				else if (cur_ff.is_fill && cur_ff.addr != cur_ff.last)
				begin
					nxt_cur.addr = cur_ff.addr + 11'h001;
					nxt_cur.st = ST_SETUP;
				end
				// next consecutive byte of the read
				else if (!cur_ff.is_write && cur_ff.left > 3'h1)
				begin
					nxt_cur.addr = cur_ff.addr + 11'h001;
					nxt_cur.left = cur_ff.left - 3'h1;
					nxt_cur.idx = cur_ff.idx + 3'h1;
					nxt_cur.st = ST_SETUP;
				end
				else if (cur_ff.is_write)
				begin
					nxt_cur.wr_done = 1'b1;
					nxt_cur.clr_wr = 1'b1;
					nxt_cur.busy = 1'b0;
				end
				else
				begin
					nxt_cur.rd_done = 1'b1;
					nxt_cur.clr_rd = 1'b1;
					nxt_cur.busy = 1'b0;
				end
			end
			default:
				nxt_cur.st = ST_IDLE;
		endcase
		// pins follow the next address, so they lead the strobe by a cycle
		// costs a cycle per access, buys address and data setup margin
		// memory stays selected, no select pin exists
		// fourteen address pins, upper ones zero
		nxt_cur.mem.addr = {{(ADDR_PINS - ADDR_BITS){1'b0}}, nxt_cur.addr};
		// write byte settles together with the address
		nxt_cur.mem.dout = nxt_cur.wbyte;
	end

	// every register on the one clock
	// single register stage, reset to idle
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			cur_ff <= '0;
			cur_ff.st <= ST_IDLE;
			cur_ff.mem.addr <= RST_MEM_ADDR;
			cur_ff.mem.dout <= RST_BYTE;
			cur_ff.mem.write_strobe_n <= 1'b1;
			cur_ff.mem.output_enable_n <= 1'b1;
			cur_ff.mem.read_write_level <= 1'b1;
		end
		else
			cur_ff <= nxt_cur;
	end

	// outputs straight from flops
	assign o_mem = cur_ff.mem;
	assign o_read_data = cur_ff.rdata;
	assign o_upd_ready = cur_ff.upd_ready;
	assign o_upd_rdata = cur_ff.upd_rdata;
	assign o_upd_rvalid = cur_ff.upd_rvalid;
	assign o_clear_begin_read = cur_ff.clr_rd;
	assign o_clear_begin_write = cur_ff.clr_wr;
	assign o_read_done_flag = cur_ff.rd_done;
	assign o_write_done_flag = cur_ff.wr_done;
	assign o_busy = cur_ff.busy;

endmodule : asa_sram_engine

// ### sim/asa_sram_engine_props.sv
`timescale 1ns/1ps
// pin-level rules of the memory engine
module asa_sram_engine_props
	import asa_pkg::*;
(
	input wire logic i_clock, // clock
	input wire logic i_resetn, // reset, active low
	input wire asa_cfg_s i_cfg, // control bits
	input wire asa_mem_s o_mem, // memory pins
	input wire logic o_upd_ready, // update taken
	input wire logic o_upd_rvalid, // update over
	input wire logic o_read_done_flag, // read done
	input wire logic o_write_done_flag, // write done
	input wire logic o_clear_begin_read, // drop begin-read
	input wire logic o_clear_begin_write, // drop begin-write
	input wire logic o_busy // cycle running
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	a_top_addr_zero: assert property (o_mem.addr[13:11] == 3'h0)
		else $error("upper address set");
	a_small_bit10: assert property (o_busy && !i_cfg.size_2k |-> !o_mem.addr[10])
		else $error("bit 10 in 1k mode");
	a_one_strobe: assert property (o_mem.write_strobe_n || o_mem.output_enable_n)
		else $error("both strobes low");
	a_write_level: assert property (!o_mem.write_strobe_n |-> !o_mem.read_write_level && o_mem.dout_oe)
		else $error("bad write level");
	a_read_level: assert property (!o_mem.output_enable_n |-> o_mem.read_write_level && !o_mem.dout_oe)
		else $error("bad read level");
	a_strobe_stable: assert property (!o_mem.write_strobe_n |-> $stable(o_mem.addr) && $stable(o_mem.dout))
		else $error("moved under strobe");
	a_data_hold: assert property ($fell(o_mem.write_strobe_n) |=> o_mem.write_strobe_n && o_mem.dout_oe)
		else $error("bad strobe width");
	a_oe_width: assert property ($fell(o_mem.output_enable_n) |=> o_mem.output_enable_n)
		else $error("bad enable width");
	a_read_done: assert property (o_read_done_flag |-> o_clear_begin_read && !o_busy)
		else $error("read done alone");
	a_write_done: assert property (o_write_done_flag |-> o_clear_begin_write && !o_busy)
		else $error("write done alone");
	a_upd_answer: assert property (o_upd_ready |-> ##[3:4] o_upd_rvalid)
		else $error("update late");
	a_reset_state: assert property (disable iff (1'b0) !i_resetn |=> o_mem.write_strobe_n && !o_busy)
		else $error("reset state");
	// main scenarios seen
	c_read: cover property (o_read_done_flag);
	c_write: cover property (o_write_done_flag);
	c_upd: cover property (o_upd_rvalid);
endmodule : asa_sram_engine_props

bind asa_sram_engine asa_sram_engine_props u_asa_sram_engine_props (.i_clock, .i_resetn, .i_cfg, .o_mem,
	.o_upd_ready, .o_upd_rvalid, .o_read_done_flag, .o_write_done_flag, .o_clear_begin_read,
	.o_clear_begin_write, .o_busy);

// ### sim/asa_sram_model.sv
`timescale 1ns/1ps
// behavioural byte-wide static memory
module asa_sram_model
	import asa_pkg::*;
(
	input wire logic i_clock, // clock
	input wire asa_mem_s i_mem, // pins from device
	output logic [7:0] o_data // data line level
);
	logic [7:0] mem [0:2047]; // 2k array
	logic [7:0] last_ff; // last line level
	logic drv; // memory drives lines
	initial
	begin
		last_ff = 8'h00;
		for (int k = 0; k < 2048; k++)
			mem[k] = 8'h00;
	end
	// no select pin, reads on level high
	assign drv = !i_mem.output_enable_n && i_mem.read_write_level;
	// released lines toggle so no stale byte passes
	assign o_data = i_mem.dout_oe ? i_mem.dout : drv ? mem[i_mem.addr[10:0]] : ~last_ff;
	always @(posedge i_clock)
	begin
		last_ff <= o_data;
		if (!i_mem.write_strobe_n && !i_mem.read_write_level)
			mem[i_mem.addr[10:0]] <= i_mem.dout;
	end
endmodule : asa_sram_model

// ### sim/test_asa_sram_engine.sv
`timescale 1ns/1ps
// request sequences against the engine
module test_asa_sram_engine;
	import asa_pkg::*;
	logic i_clock, i_resetn, upd_ready, upd_rvalid, clr_rd, clr_wr, rd_done, wr_done, busy;
	asa_cfg_s i_cfg; // software bits
	asa_upd_s i_upd; // update request
	asa_mem_s pins; // memory pins
	logic [7:0] upd_rdata, din; // update byte, line level
	logic [47:0] rdata, exp; // holding bytes, expected
	int error_cnt, compares, n;
	asa_sram_engine u_asa_sram_engine (.i_clock(i_clock), .i_resetn(i_resetn), .i_cfg(i_cfg),
		.i_upd(i_upd), .o_upd_ready(upd_ready), .o_upd_rdata(upd_rdata), .o_upd_rvalid(upd_rvalid),
		.i_memory_data_in(din), .o_mem(pins), .o_read_data(rdata), .o_clear_begin_read(clr_rd),
		.o_clear_begin_write(clr_wr), .o_read_done_flag(rd_done), .o_write_done_flag(wr_done), .o_busy(busy));
	asa_sram_model u_asa_sram_model (.i_clock(i_clock), .i_mem(pins), .o_data(din));
	initial
	begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic chk(input logic [64:0] got, input logic [64:0] want);
		compares++;
		if (got !== want)
		begin
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, want);
			error_cnt++;
		end
	endtask : chk
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// bounded wait: 0 read done, 1 write done, 2 ready, 3 rvalid
	task automatic wait_for(input int sel, output int cyc);
		logic [3:0] f;
		cyc = 0;
		do
		begin
			@(negedge i_clock);
			cyc++;
			f = {upd_rvalid, upd_ready, wr_done, rd_done};
			if (cyc > 7000)
			begin
				error_cnt++;
				wrap_up();
			end
		end
		while (f[sel] !== 1'b1);
	endtask : wait_for
	// software sets a begin bit, drops it on the clear pulse
	task automatic cpu(input logic rd, output int cyc);
		@(negedge i_clock);
		i_cfg.begin_read = rd;
		i_cfg.begin_write = !rd;
		wait_for(rd ? 0 : 1, cyc);
		chk({clr_rd, clr_wr}, rd ? 2'h2 : 2'h1);
		i_cfg.begin_read = 1'b0;
		i_cfg.begin_write = 1'b0;
	endtask : cpu
	// update request held until taken
	task automatic upd(input logic wr, input logic [10:0] a, input logic [7:0] d);
		int c;
		@(negedge i_clock);
		i_upd = '{1'b1, wr, a, d};
		wait_for(2, c);
		i_upd.valid = 1'b0;
		wait_for(3, c);
	endtask : upd
	initial
	begin
		error_cnt = 0;
		compares = 0;
		i_resetn = 1'b0;
		i_cfg = '0;
		i_upd = '0;
		repeat (4) @(negedge i_clock);
		chk({pins.write_strobe_n, pins.output_enable_n, busy, pins.addr, rdata}, {3'h6, 62'h0});
		i_resetn = 1'b1;
		i_cfg.size_2k = 1'b1;
		i_cfg.port = 4'h3;
		i_cfg.offset = 6'h2c;
		i_cfg.wdata = 8'ha5;
		cpu(1'b0, n);
		chk({u_asa_sram_model.mem[11'h0ec], n[7:0]}, 16'ha505);
		$display("end of write test");
		// whole memory fill, 1k then 2k
		for (int s = 0; s < 2; s++)
		begin
			i_cfg.size_2k = s[0];
			i_cfg.fill = 1'b1;
			i_cfg.wdata = 8'h5a ^ s[7:0];
			cpu(1'b0, n);
			chk({u_asa_sram_model.mem[0], u_asa_sram_model.mem[11'h3ff], u_asa_sram_model.mem[11'h400],
				u_asa_sram_model.mem[11'h7ff]}, s ? {4{8'h5b}} : 32'h5a5a0000);
		end
		$display("end of fill test");
		// reads of every length, longest first so stale bytes show
		i_cfg.fill = 1'b0;
		i_cfg.hub_sel = 1'b1;
		i_cfg.port = 4'hc;
		i_cfg.offset = 6'h30;
		for (int k = 0; k < 8; k++)
			u_asa_sram_model.mem[11'h730 + k] = 8'hc0 + k[7:0];
		for (int len = 7; len >= 0; len--)
		begin
			i_cfg.rd_len = len[2:0];
			i_cfg.speed_slow = len[0];
			cpu(1'b1, n);
			exp = '0;
			for (int k = 0; k < 6; k++)
				if (k < len || k == 0)
					exp[8*k +: 8] = 8'hc0 + k[7:0];
			chk(rdata, exp);
			chk(n, 2 + (len == 0 ? 1 : len > 6 ? 6 : len) * (2 + (len[0] ? ACC_SLOW_CYC : ACC_FAST_CYC)));
		end
		i_cfg.size_2k = 1'b0;
		i_cfg.rd_len = 3'h1;
		u_asa_sram_model.mem[11'h330] = 8'h99;
		cpu(1'b1, n);
		chk(rdata, 48'h99);
		$display("end of read test");
		// update racing a cpu read, then update read back
		i_cfg.size_2k = 1'b1;
		i_cfg.hub_sel = 1'b0;
		i_cfg.port = 4'h0;
		i_cfg.offset = 6'h37;
		u_asa_sram_model.mem[11'h037] = 8'h3c;
		fork
			upd(1'b1, 11'h123, 8'h77);
			cpu(1'b1, n);
		join
		chk(rdata, 48'h3c);
		upd(1'b0, 11'h123, 8'h00);
		chk({u_asa_sram_model.mem[11'h123], upd_rdata}, 16'h7777);
		$display("end of update test");
		i_resetn = 1'b0;
		repeat (2) @(negedge i_clock);
		chk({busy, rdata}, 49'h0);
		i_resetn = 1'b1;
		cpu(1'b1, n);
		chk(rdata, 48'h3c);
		$display("end of reset test");
		wrap_up();
	end
endmodule : test_asa_sram_engine
